// >>> include/lnr_consts.svh
`ifndef LNR_CONSTS_SVH
`define LNR_CONSTS_SVH

// system clock rate
`define LNR_CLK_HZ 25000000
// tone reference and converter ratio
`define LNR_TONE_HZ 22000
`define LNR_CONV_RATIO 16
`define LNR_CONV_HZ (`LNR_TONE_HZ * `LNR_CONV_RATIO)
// cycles per half converter period, rounded down
`define LNR_CONV_HALF (`LNR_CLK_HZ / (2 * `LNR_CONV_HZ))
// overcurrent disable time
`define LNR_ODT_MS 48
`define LNR_ODT_CYC (`LNR_ODT_MS * (`LNR_CLK_HZ / 1000))

// serial slave address, fixed upper bits
`define LNR_DEV_ADDR_HI 5'h02
// control register selectors in data bits 7:6
`define LNR_CREG_MAIN 2'h0
`define LNR_CREG_TONE 2'h2
// bits per serial byte
`define LNR_BYTE_BITS 4'h8

// register bus byte offsets
`define LNR_OFF_CTRL0 4'h0
`define LNR_OFF_CTRL1 4'h4
`define LNR_OFF_STAT 4'h8
`define LNR_OFF_DIAG 4'hc

`endif

// >>> include/lnr_pkg.sv
package lnr_pkg;

  // main control register, data bits 5:0
  typedef struct packed {
    logic enable;
    logic overcurrent_disable_timer;
    logic [3:0] vsel;
  } lnr_ctrl_main_t;

  // tone control register, data bits 1:0
  typedef struct packed {
    logic tone_gate;
    logic tone_source_select;
  } lnr_tone_cfg_t;

  // tone drive toward the analog modulator
  typedef struct packed {
    logic active;
    logic high;
  } lnr_tone_out_t;

  // serial transfer sequence
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_addr = 3'h1,
    st_addr_ack = 3'h2,
    st_wdata = 3'h3,
    st_wack = 3'h4,
    st_rdata = 3'h5,
    st_rack = 3'h6,
    st_wait_stop = 3'h7
  } lnr_ser_state_t;

endpackage

// >>> hw/lnr_tone_gen.sv
`include "lnr_consts.svh"

module lnr_tone_gen
  import lnr_pkg::*;
#(
  parameter int CONV_HALF = `LNR_CONV_HALF,
  parameter int CONV_RATIO = `LNR_CONV_RATIO
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // configuration and synchronised pin
  input lnr_tone_cfg_t tone_cfg,
  input wire logic ext_tone,
  // outputs
  output logic conv_clk,
  output lnr_tone_out_t tone_out
);

  localparam int HW = $clog2(CONV_HALF + 1);
  localparam int RW = $clog2(CONV_RATIO);

  // the tone is derived by counting converter toggles, so the ratio must be a power of two
  generate
    if (CONV_HALF < 1 || CONV_RATIO < 2 || (1 << RW) != CONV_RATIO)
    begin : g_bad
      $error("lnr_tone_gen: unsupported divider settings");
    end
  endgenerate

  logic [HW-1:0] half_cnt_reg;
  logic [RW-1:0] tog_cnt_reg;
  logic conv_reg;
  logic tone_int_reg;
  lnr_tone_out_t tone_reg;

  // converter clock at ratio times the tone rate
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      half_cnt_reg <= '0;
      conv_reg <= 1'b0;
    end
    else if (half_cnt_reg == HW'(CONV_HALF - 1))
    begin
      half_cnt_reg <= '0;
      conv_reg <= ~conv_reg; // [RULE1]
    end
    else
    begin
      half_cnt_reg <= half_cnt_reg + 1'b1;
    end
  end

  // internal tone: one toggle per ratio converter toggles
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tog_cnt_reg <= '0;
      tone_int_reg <= 1'b0;
    end
    else if (half_cnt_reg == HW'(CONV_HALF - 1))
    begin
      tog_cnt_reg <= tog_cnt_reg + 1'b1;
      if (tog_cnt_reg == RW'(CONV_RATIO - 1))
      begin
        tone_int_reg <= ~tone_int_reg; // [RULE1]
      end
    end
  end

  // four tone options from source select, gate bit and pin
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tone_reg <= '0;
    end
    else if (tone_cfg.tone_source_select) // [RULE6]
    begin
      tone_reg.active <= tone_cfg.tone_gate; // [RULE7]
      tone_reg.high <= tone_int_reg;
    end
    else if (tone_cfg.tone_gate)
    begin
      tone_reg.active <= ext_tone; // [RULE7]
      tone_reg.high <= tone_int_reg;
    end
    else
    begin
      // direct mode: a still pin parks the offset at its level
      tone_reg.active <= 1'b1;
      tone_reg.high <= ext_tone; // [RULE8]
    end
  end

  assign conv_clk = conv_reg;
  assign tone_out = tone_reg;

endmodule

// >>> hw/lnr_serial_ctrl.sv
// Notes on behaviour
// [RULE1] converter clock runs at sixteen times the internal 22 kHz tone.
// [RULE2] overcurrent held beyond 48 ms disables output and latches the fault flag.
// [RULE3] after shutdown the output stays off until the host enables again.
// [RULE4] host waits at least 2 s between re-enable attempts.
// [RULE5] a surge shorter than 48 ms raises no fault.
// [RULE6] tone source select picks internal oscillator or external pin.
// [RULE7] external pin and gate bit give four tone options.
// [RULE8] direct external mode parks the offset at the pin level.
// [RULE9] start is data falling while clock high; detected.
// [RULE10] address is seven bits, direction bit, then acknowledge.
// [RULE11] address upper five bits 00010, low two from address select.
// [RULE12] address byte travels most significant bit first.
// [RULE13] write byte holds six data bits and two register select bits.
// [RULE14] reads alternate status one and status two.
// [RULE15] each read transfer starts with status one.
// [RULE16] status bytes shift out most significant bit first.
// [RULE17] stop is data rising while clock high; detected.
// [RULE18] data changes only while clock low, outside start and stop.
// [RULE19] start or stop at any time resets the transfer sequence.
// [RULE20] master drives the clock; data line is input or open drain.
// [RULE21] valid address and each written byte get a low acknowledge.
// [RULE22] on reads release for ninth clock; continue only on master acknowledge.
// [RULE23] master sends one data byte per write transfer.
// [RULE24] foreign address: line stays released, rest of transfer ignored.
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`include "lnr_consts.svh"

module lnr_serial_ctrl
  import lnr_pkg::*;
#(
  parameter int ODT_CYCLES = `LNR_ODT_CYC
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // two-wire serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_sel,
  // tone and overcurrent pins
  input wire logic external_tone_input,
  input wire logic overcurrent_in,
  // regulator controls
  output logic lnb_enable,
  output logic [3:0] vsel,
  output logic conv_clk,
  output lnr_tone_out_t tone_out
);

  localparam int OW = $clog2(ODT_CYCLES + 1);

  // a zero disable time would trip on the first overcurrent cycle
  generate
    if (ODT_CYCLES < 1)
    begin : g_bad
      $error("lnr_serial_ctrl: ODT_CYCLES must be at least 1");
    end
  endgenerate

  // pin synchroniser order: addr_sel, overcurrent, tone, sda, scl
  logic [5:0] pin_meta_reg;
  logic [5:0] pin_sync_reg;
  logic scl_s;
  logic sda_s;
  logic ext_s;
  logic oc_s;
  logic [1:0] asel_s;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // serial engine state
  lnr_ser_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic rw_reg;
  logic next_two_reg;
  logic master_ack_reg;
  logic sda_oe_reg;
  logic wr_commit;
  logic rd_load;
  logic [7:0] rd_byte;

  // control, fault and diagnostic state
  lnr_ctrl_main_t ctrl_main_reg;
  lnr_tone_cfg_t tone_cfg_reg;
  logic fault_reg;
  logic fault_clear;
  logic [OW-1:0] odt_cnt_reg;
  logic odt_run;
  logic odt_trip;
  logic [15:0] diag_reg;
  logic [7:0] status1;
  logic [7:0] status2;

  // bus slave state
  logic ack_reg;
  logic [31:0] rdata_reg;

  // two flops on every pin before any logic looks at it
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pin_meta_reg <= 6'h3f;
      pin_sync_reg <= 6'h3f;
    end
    else
    begin
      pin_meta_reg <= {addr_sel, overcurrent_in, external_tone_input, sda_in, scl_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign scl_s = pin_sync_reg[0];
  assign sda_s = pin_sync_reg[1];
  assign ext_s = pin_sync_reg[2];
  assign oc_s = pin_sync_reg[3];
  assign asel_s = pin_sync_reg[5:4];

  // previous line levels for edge detection
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // data edges count as conditions only with the clock high on both samples
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s; // [RULE9]
  assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s; // [RULE17]

  // status bytes: first one has bus bits 7:3 over our own state in bits 2:0, second wholly from the bus
  assign status1 = {diag_reg[7:3], oc_s, ~ctrl_main_reg.enable, fault_reg};
  assign status2 = diag_reg[15:8];
  assign rd_byte = next_two_reg ? status2 : status1; // [RULE14]

  // serial transfer sequence, sampling on clock rise and driving on fall
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= st_idle;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rw_reg <= 1'b0;
      next_two_reg <= 1'b0;
      master_ack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg <= st_addr; // [RULE19]
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
      next_two_reg <= 1'b0; // [RULE15]
    end
    else if (stop_det)
    begin
      state_reg <= st_idle; // [RULE19]
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        st_addr, st_wdata:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_s}; // [RULE12]
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (scl_fall && bit_cnt_reg == `LNR_BYTE_BITS)
          begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == st_wdata)
            begin
              state_reg <= st_wack;
              sda_oe_reg <= 1'b1; // [RULE21]
            end
            else if (shift_reg[7:1] == {`LNR_DEV_ADDR_HI, asel_s}) // [RULE11]
            begin
              rw_reg <= shift_reg[0]; // [RULE10]
              state_reg <= st_addr_ack;
              sda_oe_reg <= 1'b1; // [RULE21]
            end
            else
            begin
              state_reg <= st_wait_stop; // [RULE24]
            end
          end
        end
        st_addr_ack:
        begin
          if (scl_fall)
          begin
            if (rw_reg)
            begin
              // first status bit goes out as the ack clock falls
              state_reg <= st_rdata;
              shift_reg <= {rd_byte[6:0], 1'b0};
              sda_oe_reg <= ~rd_byte[7]; // [RULE16]
              next_two_reg <= ~next_two_reg;
            end
            else
            begin
              state_reg <= st_wdata;
              sda_oe_reg <= 1'b0; // [RULE20]
            end
          end
        end
        st_wack:
        begin
          // a second data byte would need a new address phase
          if (scl_fall)
          begin
            state_reg <= st_wait_stop; // [RULE23]
            sda_oe_reg <= 1'b0;
          end
        end
        st_rdata:
        begin
          if (scl_rise)
          begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (scl_fall)
          begin
            if (bit_cnt_reg == `LNR_BYTE_BITS)
            begin
              bit_cnt_reg <= 4'h0;
              state_reg <= st_rack;
              sda_oe_reg <= 1'b0; // [RULE22]
            end
            else
            begin
              sda_oe_reg <= ~shift_reg[7]; // [RULE16]
              shift_reg <= {shift_reg[6:0], 1'b0};
            end
          end
        end
        st_rack:
        begin
          if (scl_rise)
          begin
            master_ack_reg <= ~sda_s;
          end
          else if (scl_fall)
          begin
            if (master_ack_reg)
            begin
              state_reg <= st_rdata; // [RULE22]
              shift_reg <= {rd_byte[6:0], 1'b0};
              sda_oe_reg <= ~rd_byte[7];
              next_two_reg <= ~next_two_reg; // [RULE14]
            end
            else
            begin
              state_reg <= st_wait_stop; // [RULE22]
            end
          end
        end
        default:
        begin
          // idle and waiting for stop keep the line released
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // a byte load happens when the ack clock falls into a data byte
  assign rd_load = scl_fall & ~start_det & ~stop_det
                   & ((state_reg == st_addr_ack & rw_reg) | (state_reg == st_rack & master_ack_reg));
  // status one read out releases its latched fault
  assign fault_clear = rd_load & ~next_two_reg;
  // a write byte takes effect when its eighth bit is complete
  assign wr_commit = scl_fall & ~start_det & ~stop_det & state_reg == st_wdata
                     & bit_cnt_reg == `LNR_BYTE_BITS;

  // control registers written through the serial port
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_main_reg <= '0;
      tone_cfg_reg <= '0;
    end
    else
    begin
      if (wr_commit && shift_reg[7:6] == `LNR_CREG_MAIN)
      begin
        ctrl_main_reg <= lnr_ctrl_main_t'(shift_reg[5:0]); // [RULE13]
      end
      if (wr_commit && shift_reg[7:6] == `LNR_CREG_TONE)
      begin
        tone_cfg_reg <= lnr_tone_cfg_t'(shift_reg[1:0]); // [RULE13]
      end
      // the trip wins over a write in the same cycle; only a later write restarts
      if (odt_trip)
      begin
        ctrl_main_reg.enable <= 1'b0; // [RULE3]
      end
    end
  end

  // overcurrent must be continuous; any gap restarts the count
  assign odt_run = oc_s & ctrl_main_reg.enable;
  assign odt_trip = odt_run & (odt_cnt_reg == OW'(ODT_CYCLES)); // [RULE2]

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      odt_cnt_reg <= '0;
    end
    else if (!odt_run)
    begin
      odt_cnt_reg <= '0; // [RULE5]
    end
    else if (odt_cnt_reg != OW'(ODT_CYCLES))
    begin
      odt_cnt_reg <= odt_cnt_reg + 1'b1; // [RULE5]
    end
  end

  // latched fault flag, the trip wins over a clear
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      fault_reg <= 1'b0;
    end
    else if (odt_trip)
    begin
      fault_reg <= 1'b1; // [RULE2]
    end
    else if (fault_clear)
    begin
      fault_reg <= 1'b0;
    end
  end

  // bus answer: one wait cycle, request taken on the second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ack_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  // read data captured in the wait cycle, stands while waitrequest is low
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdata_reg <= 32'h0;
    end
    else if (avs_read && !ack_reg)
    begin
      if (avs_address == `LNR_OFF_CTRL0)
      begin
        rdata_reg <= {26'h0, ctrl_main_reg};
      end
      else if (avs_address == `LNR_OFF_CTRL1)
      begin
        rdata_reg <= {30'h0, tone_cfg_reg};
      end
      else if (avs_address == `LNR_OFF_STAT)
      begin
        rdata_reg <= {16'h0, status2, status1};
      end
      else if (avs_address == `LNR_OFF_DIAG)
      begin
        rdata_reg <= {16'h0, diag_reg};
      end
      else
      begin
        rdata_reg <= 32'h0;
      end
    end
  end

  assign avs_readdata = rdata_reg;

  // diagnostic bits supplied by system software, per byte lane
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      diag_reg <= 16'h0;
    end
    else if (avs_write && ack_reg && avs_address == `LNR_OFF_DIAG)
    begin
      if (avs_byteenable[0])
      begin
        diag_reg[7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1])
      begin
        diag_reg[15:8] <= avs_writedata[15:8];
      end
    end
  end

  // tone and converter clock
  lnr_tone_gen lnr_tone_gen_i
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .tone_cfg(tone_cfg_reg),
    .ext_tone(ext_s),
    .conv_clk(conv_clk),
    .tone_out(tone_out)
  );

  // open drain: only ever pull low
  assign sda_out = 1'b0; // [RULE20]
  assign sda_oe = sda_oe_reg; // [RULE18]
  assign lnb_enable = ctrl_main_reg.enable; // [RULE3]
  assign vsel = ctrl_main_reg.vsel;

endmodule

// >>> tb/lnr_serial_ctrl_properties.sv
module lnr_serial_ctrl_properties #(
  parameter int ODT_CYCLES = 1200000
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // regulator side
  input wire logic overcurrent_in,
  input wire logic lnb_enable,
  input wire logic [3:0] vsel,
  input wire logic conv_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  int oc_run;
  logic [7:0] cv_run;
  logic cv_q;
  logic cv_seen;

  // overcurrent run length while the output is on; two sync flops add slack
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      oc_run <= 0;
    else
      oc_run <= (overcurrent_in && lnb_enable) ? oc_run + 1 : 0;
  end

  // cycles between converter edges; the first edge after reset has no reference
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cv_q <= 1'h0;
      cv_run <= 8'h00;
      cv_seen <= 1'h0;
    end
    else
    begin
      cv_q <= conv_clk;
      cv_run <= (conv_clk != cv_q) ? 8'h00 : cv_run + 8'h01;
      cv_seen <= cv_seen || (conv_clk != cv_q);
    end
  end

  conv_rate_a: assert property (cv_seen && conv_clk != cv_q |-> cv_run == 8'h22)
    else $error("converter half period wrong");
  oc_trip_a: assert property (overcurrent_in && lnb_enable |-> oc_run <= ODT_CYCLES + 4)
    else $error("overcurrent not tripped in time");
  surge_hold_a: assert property ($fell(lnb_enable) && $past(overcurrent_in) |-> $past(oc_run) >= ODT_CYCLES)
    else $error("tripped on a short surge");
  no_restart_a: assert property ($rose(lnb_enable) |-> $rose(sda_oe))
    else $error("output enabled without a host write");
  vsel_write_a: assert property ($changed(vsel) |-> $rose(sda_oe))
    else $error("voltage select changed outside a write");
  oe_low_clk_a: assert property ($rose(sda_oe) |-> !$past(scl_in))
    else $error("data line taken while clock high");
  stop_idle_a: assert property (scl_in && $past(scl_in) && $rose(sda_in) |=> !sda_oe [*4])
    else $error("data line driven after stop");
  open_drain_a: assert property (sda_out == 1'h0)
    else $error("data line driven high");
  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule

// >>> tb/lnr_i2c_master_model.sv
module lnr_i2c_master_model (
  // clock
  input wire logic clk_sys,
  // bus lines, data resolved outside with pull-up
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus: clock high, data released
  initial
  begin
    scl = 1'h1;
    sda_low = 1'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // also a repeated start when entered with the clock low
  task automatic start_cond();
    sda_low <= 1'h0;
    tick(2);
    scl <= 1'h1;
    tick(4);
    sda_low <= 1'h1;
    tick(4);
    scl <= 1'h0;
    tick(2);
  endtask

  // data moves only in the low phase; 8 clk per bit gives 320 ns
  task automatic bit_xfer(input logic b, output logic r);
    sda_low <= !b;
    tick(2);
    scl <= 1'h1;
    tick(4);
    r = sda_in;
    scl <= 1'h0;
    tick(2);
  endtask

  // ack_in low acknowledges a read byte; tx all ones releases the line
  task automatic xfer_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(tx[i], r);
      rx[i] = r;
    end
    bit_xfer(ack_in, ack);
  endtask

  task automatic stop_cond();
    sda_low <= 1'h1;
    tick(2);
    scl <= 1'h1;
    tick(4);
    sda_low <= 1'h0;
    tick(8);
  endtask
endmodule

// >>> tb/lnr_serial_ctrl_tb.sv
`include "lnr_consts.svh"

module lnr_serial_ctrl_tb;
  import lnr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OVERCURRENT_DISABLE_TIMER = 20;
  logic clk_sys;
  logic rst;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] addr_sel;
  logic ext_tone;
  logic oc;
  logic sda_out;
  logic sda_oe;
  logic scl;
  logic sda_low;
  logic lnb_enable;
  logic [3:0] vsel;
  logic conv_clk;
  lnr_tone_out_t tone_out;
  int failures = 0;
  int samples_checked = 0;
  // wired-and data line with pull-up
  wire sda = !(sda_low || (sda_oe && !sda_out));

  lnr_serial_ctrl #(.ODT_CYCLES(OVERCURRENT_DISABLE_TIMER)) lnr_serial_ctrl_i (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_sel(addr_sel), .external_tone_input(ext_tone), .overcurrent_in(oc), .lnb_enable(lnb_enable),
    .vsel(vsel), .conv_clk(conv_clk), .tone_out(tone_out));

  lnr_i2c_master_model m_i (.clk_sys(clk_sys), .sda_in(sda), .scl(scl), .sda_low(sda_low));

  // 25 MHz system clock
  initial
  begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic final_report();
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until the rising edge at which waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'h0 && n < 50)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 50)
    begin
      failures++;
      final_report();
    end
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask

  task automatic ser_write(input logic [7:0] a, input logic [7:0] d, output logic aa, output logic da);
    logic [7:0] rx;
    m_i.start_cond();
    m_i.xfer_byte(a, 1'h1, rx, aa);
    m_i.xfer_byte(d, 1'h1, rx, da);
    m_i.stop_cond();
  endtask

  task automatic ser_read1(output logic [7:0] rx);
    logic a;
    m_i.start_cond();
    m_i.xfer_byte(8'h13, 1'h1, rx, a);
    m_i.xfer_byte(8'hff, 1'h1, rx, a);
    m_i.stop_cond();
  endtask

  task automatic t_bus_regs();
    logic [31:0] d;
    bus(1'h0, 4'h0, 32'h0, d);
    chk("ctrl0 reset", d, 32'h0);
    bus(1'h1, 4'hc, 32'h00005af8, d);
    bus(1'h1, 4'h0, 32'hffffffff, d);
    bus(1'h0, 4'h0, 32'h0, d);
    chk("ctrl0 read only", d, 32'h0);
    bus(1'h0, 4'h2, 32'h0, d);
    chk("unmapped", d, 32'h0);
    bus(1'h0, 4'hc, 32'h0, d);
    chk("diag", d, 32'h00005af8);
    bus(1'h0, 4'h8, 32'h0, d);
    chk("status disabled", d, 32'h00005afa);
  endtask

  task automatic t_address();
    logic aa;
    logic da;
    for (int k = 0; k < 4; k++)
    begin
      addr_sel <= 2'(k);
      repeat (4) @(posedge clk_sys);
      ser_write({5'h02, 2'(k), 1'h0}, 8'h80, aa, da);
      chk("own address ack", aa, 1'h0);
      ser_write({5'h02, 2'(k + 1), 1'h0}, 8'h2b, aa, da);
      chk("foreign address", {aa, da, lnb_enable}, 3'h6);
    end
    addr_sel <= 2'h1;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic t_write_main();
    logic [31:0] d;
    logic aa;
    logic da;
    ser_write(8'h12, 8'h2b, aa, da);
    chk("write acks", {aa, da}, 2'h0);
    chk("main outputs", {lnb_enable, vsel}, 5'h1b);
    bus(1'h0, 4'h0, 32'h0, d);
    chk("ctrl0 written", d, 32'h2b);
    ser_write(8'h12, 8'h45, aa, da);
    chk("unused selector", {da, vsel}, 5'h0b);
  endtask

  task automatic t_read();
    logic [7:0] rx;
    logic a;
    m_i.start_cond();
    m_i.xfer_byte(8'h13, 1'h1, rx, a);
    chk("read address ack", a, 1'h0);
    for (int i = 0; i < 3; i++)
    begin
      m_i.xfer_byte(8'hff, i == 2, rx, a);
      chk("status byte", rx, (i == 1) ? 8'h5a : 8'hf8);
    end
    m_i.xfer_byte(8'hff, 1'h1, rx, a);
    chk("released after nack", rx, 8'hff);
    m_i.start_cond();
    m_i.xfer_byte(8'h13, 1'h1, rx, a);
    m_i.xfer_byte(8'hff, 1'h1, rx, a);
    chk("restart status one", rx, 8'hf8);
    m_i.stop_cond();
  endtask

  task automatic t_tone();
    logic [31:0] d;
    logic aa;
    logic da;
    logic h;
    int n;
    for (int c = 0; c < 4; c++)
    begin
      ser_write(8'h12, {6'h20, 2'(c)}, aa, da);
      bus(1'h0, 4'h4, 32'h0, d);
      chk("tone cfg", d, 32'(c));
      for (int p = 0; p < 2; p++)
      begin
        ext_tone <= p[0];
        repeat (6) @(posedge clk_sys);
        chk("tone active", tone_out.active, c[0] ? c[1] : (c[1] ? p[0] : 1'h1));
        if (c == 0)
          chk("tone park", tone_out.high, p[0]);
      end
    end
    // internal source keeps toggling with the pin held still
    h = tone_out.high;
    for (n = 0; n < 600 && tone_out.high === h; n++)
      @(posedge clk_sys);
    chk("internal tone", tone_out.high, !h);
    // one tone half period spans sixteen converter half periods
    for (n = 0; n < 600 && tone_out.high === !h; n++)
      @(posedge clk_sys);
    chk("tone half period", n, 16 * `LNR_CONV_HALF);
  endtask

  task automatic t_overcurrent();
    logic [7:0] rx;
    logic aa;
    logic da;
    oc <= 1'h1;
    repeat (OVERCURRENT_DISABLE_TIMER - 4) @(posedge clk_sys);
    oc <= 1'h0;
    repeat (10) @(posedge clk_sys);
    chk("surge tolerated", lnb_enable, 1'h1);
    oc <= 1'h1;
    repeat (OVERCURRENT_DISABLE_TIMER + 10) @(posedge clk_sys);
    chk("overcurrent trip", lnb_enable, 1'h0);
    oc <= 1'h0;
    repeat (100) @(posedge clk_sys);
    chk("no self restart", lnb_enable, 1'h0);
    ser_read1(rx);
    chk("fault latched", rx, 8'hfb);
    ser_read1(rx);
    chk("fault cleared by read", rx, 8'hfa);
    // a single host retry, so the spacing between attempts cannot be broken here
    ser_write(8'h12, 8'h2b, aa, da);
    chk("re-enable", lnb_enable, 1'h1);
  endtask

  // reset held for 20 cycles, then each scenario in turn
  initial
  begin
    rst = 1'h1;
    avs_address = 4'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    addr_sel = 2'h1;
    ext_tone = 1'h0;
    oc = 1'h0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    t_bus_regs();
    t_address();
    t_write_main();
    t_read();
    t_tone();
    t_overcurrent();
    final_report();
  end
endmodule

bind lnr_serial_ctrl lnr_serial_ctrl_properties #(.ODT_CYCLES(ODT_CYCLES)) lnr_serial_ctrl_properties_i (
  .clk_sys(clk_sys), .rst(rst), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .overcurrent_in(overcurrent_in),
  .lnb_enable(lnb_enable), .vsel(vsel), .conv_clk(conv_clk));
